// ### spae_pkg.sv
// Operation
// - Status writes get flags from the result
// - Reading pc low copies pc high to latch
// - Writing pc low loads pc high from latch
// - Modify of pc low uses low byte, loads pc high from latch
// - Pc high is not addressable, only via latch
// - Bit instructions read, modify, write whole register
// - One instruction cycle per four oscillator periods
package spae_pkg;

    localparam int AXI_AW = 5;
    localparam logic [4:0] REG_CMD = 5'h00;
    localparam logic [4:0] REG_WORK = 5'h04;
    localparam logic [4:0] REG_STAT = 5'h08;
    localparam logic [4:0] REG_PC = 5'h0C;
    localparam logic [4:0] REG_LATCH = 5'h10;
    localparam logic [4:0] REG_FILE = 5'h14;

    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // Oscillator periods per instruction cycle; the divider wraps at the last one
    localparam int CYC_DIV = 4;
    localparam logic [1:0] CYC_LAST = 2'(CYC_DIV - 1);

    // Flag positions inside the arithmetic status register
    localparam int FLG_C = 0;
    localparam int FLG_DIGIT = 1;
    localparam int FLG_Z = 2;
    localparam int FLG_OVER = 3;

    // Command word fields
    localparam int CMD_OP_LSB = 0;
    localparam int CMD_DEST_BIT = 4;
    localparam int CMD_BSEL_LSB = 5;
    localparam int CMD_TGT_LSB = 8;
    localparam int CMD_BUSY_BIT = 8;

    localparam logic [7:0] STAT_RST = 8'h00;
    localparam logic [15:0] PC_RST = 16'h0000;
    localparam logic [7:0] BYTE_ZERO = 8'h00;
    localparam logic [7:0] BIT0_MASK = 8'h01;
    localparam logic [3:0] FLAGS_ALL = 4'hf;
    localparam logic [3:0] FLAGS_NONE = 4'h0;
    localparam logic [3:0] FLAGS_Z = 4'h4;

    typedef enum logic [3:0] {
        OP_MOVF, OP_MOVWF, OP_CLEAR, OP_ADDWF, OP_SUBWF,
        OP_ANDWF, OP_INCF, OP_BSF, OP_BCF, OP_BTG
    } spae_op_t;

    typedef enum logic [1:0] {
        TGT_STATUS, TGT_PC_LOW, TGT_LATCH, TGT_FILE
    } spae_tgt_t;

endpackage

// ### spae_alu_if.sv
interface spae_alu_if;
    import spae_pkg::*;
    logic [7:0] a;
    logic [7:0] b;
    logic [2:0] bsel;
    spae_op_t op;
    logic [7:0] y;
    logic [3:0] flags;
    modport core (output a, output b, output bsel, output op, input y, input flags);
    modport alu (input a, input b, input bsel, input op, output y, output flags);
endinterface

// ### spae_alu.sv
module spae_alu
    import spae_pkg::*;
(
    spae_alu_if.alu bus
);
    logic [7:0] addend;
    logic cin;
    logic [8:0] sum;
    logic [4:0] nib;
    logic [7:0] bmask;

    assign bmask = BIT0_MASK << bus.bsel;
    // Carry is the inverse of borrow, as a two's complement add
    assign addend = (bus.op == OP_ADDWF) ? bus.b : (bus.op == OP_SUBWF) ? ~bus.b : BYTE_ZERO;
    assign cin = (bus.op == OP_SUBWF) || (bus.op == OP_INCF);
    assign sum = {1'b0, bus.a} + {1'b0, addend} + {8'h00, cin};
    assign nib = {1'b0, bus.a[3:0]} + {1'b0, addend[3:0]} + {4'h0, cin};

    always_comb begin
        bus.y = bus.a;
        unique case (bus.op)
            OP_MOVF: bus.y = bus.a;
            OP_MOVWF: bus.y = bus.b;
            OP_CLEAR: bus.y = BYTE_ZERO;
            OP_ADDWF, OP_SUBWF, OP_INCF: bus.y = sum[7:0];
            OP_ANDWF: bus.y = bus.a & bus.b;
            // Whole register in, one bit changed, whole register out
            OP_BSF: bus.y = bus.a | bmask;
            OP_BCF: bus.y = bus.a & ~bmask;
            OP_BTG: bus.y = bus.a ^ bmask;
            default: bus.y = bus.a;
        endcase
    end

    always_comb begin
        bus.flags[FLG_C] = sum[8];
        bus.flags[FLG_DIGIT] = nib[4];
        bus.flags[FLG_Z] = (bus.y == BYTE_ZERO);
        bus.flags[FLG_OVER] = (bus.a[7] == addend[7]) && (bus.y[7] != bus.a[7]);
    end
endmodule

// ### spae_core.sv
// The AXI4-Lite slave port and the register offsets were chosen for this implementation.
module spae_core
    import spae_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [AXI_AW-1:0] s_axi_awaddr,
    input wire logic [2:0] s_axi_awprot,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [AXI_AW-1:0] s_axi_araddr,
    input wire logic [2:0] s_axi_arprot,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready
);
    // Flags each operation produces; the rest keep their old value unless the status register is the written target
    function automatic logic [3:0] flag_mask(input spae_op_t op);
        unique case (op)
            OP_ADDWF, OP_SUBWF, OP_INCF: flag_mask = FLAGS_ALL;
            OP_MOVF, OP_CLEAR, OP_ANDWF: flag_mask = FLAGS_Z;
            default: flag_mask = FLAGS_NONE;
        endcase
    endfunction

    function automatic logic to_file(input spae_op_t op, input logic dest);
        unique case (op)
            OP_MOVWF, OP_CLEAR, OP_BSF, OP_BCF, OP_BTG: to_file = 1'b1;
            OP_MOVF, OP_ADDWF, OP_SUBWF, OP_ANDWF, OP_INCF: to_file = dest;
            default: to_file = 1'b0;
        endcase
    endfunction

    function automatic logic to_work(input spae_op_t op, input logic dest);
        unique case (op)
            OP_MOVF, OP_ADDWF, OP_SUBWF, OP_ANDWF, OP_INCF: to_work = !dest;
            default: to_work = 1'b0;
        endcase
    endfunction

    function automatic logic addr_known(input logic [AXI_AW-1:0] addr);
        addr_known = (addr == REG_CMD) || (addr == REG_WORK) || (addr == REG_STAT) ||
                     (addr == REG_PC) || (addr == REG_LATCH) || (addr == REG_FILE);
    endfunction

    spae_alu_if alu_bus ();

    spae_alu u_alu (
        .bus(alu_bus.alu)
    );

    logic [1:0] div;
    logic pending;
    spae_op_t op_q;
    logic dest_q;
    logic [2:0] bsel_q;
    spae_tgt_t tgt_q;
    logic [7:0] work;
    logic [7:0] arith_status_reg;
    logic [15:0] pc;
    logic [7:0] pc_high_holding_latch;
    logic [7:0] gpr;

    logic aw_full;
    logic w_full;
    logic [AXI_AW-1:0] aw_addr_q;
    logic [31:0] w_data_q;
    logic [3:0] w_strb_q;
    logic [1:0] bresp;
    logic bvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic rvalid;

    // Instruction cycle timing
    wire cyc_en = (div == CYC_LAST);
    wire exec = cyc_en && pending;
    wire wr_f = exec && to_file(op_q, dest_q);
    wire wr_w = exec && to_work(op_q, dest_q);
    wire [3:0] fmask = flag_mask(op_q);
    wire pc_low_read_only = exec && (tgt_q == TGT_PC_LOW) && !wr_f;
    wire [7:0] pc_low_byte = pc[7:0];
    wire [7:0] pc_high_byte = pc[15:8];

    // Operand of the addressed file register; pc low is taken as it stands
    wire [7:0] file_rd = (tgt_q == TGT_STATUS) ? arith_status_reg :
                         (tgt_q == TGT_PC_LOW) ? pc_low_byte :
                         (tgt_q == TGT_LATCH) ? pc_high_holding_latch : gpr;

    assign alu_bus.a = file_rd;
    assign alu_bus.b = work;
    assign alu_bus.bsel = bsel_q;
    assign alu_bus.op = op_q;

    wire [7:0] status_merged = (arith_status_reg & ~{4'h0, fmask}) | {4'h0, alu_bus.flags & fmask};
    // Written byte first, then the produced flags replace their bits
    wire [7:0] status_written = (alu_bus.y & ~{4'h0, fmask}) | {4'h0, alu_bus.flags & fmask};
    wire [7:0] next_status = (wr_f && tgt_q == TGT_STATUS) ? status_written :
                             exec ? status_merged : arith_status_reg;
    wire [15:0] next_pc = (wr_f && tgt_q == TGT_PC_LOW) ? {pc_high_holding_latch, alu_bus.y} :
                          exec ? pc + 16'h0001 : pc;

    // Bus write decode
    wire bus_commit = aw_full && w_full && !bvalid;
    wire lane0 = w_strb_q[0];
    wire addr_ok = addr_known(aw_addr_q);
    wire wr_cmd = bus_commit && lane0 && (aw_addr_q == REG_CMD) && !pending;
    wire wr_work = bus_commit && lane0 && (aw_addr_q == REG_WORK);
    wire wr_latch = bus_commit && lane0 && (aw_addr_q == REG_LATCH);
    wire wr_gpr = bus_commit && lane0 && (aw_addr_q == REG_FILE);
    // Busy command slot and read-only registers refuse the write
    wire wr_refused = !addr_ok || (aw_addr_q == REG_STAT) || (aw_addr_q == REG_PC) ||
                      ((aw_addr_q == REG_CMD) && pending);

    assign s_axi_awready = !aw_full && !bvalid;
    assign s_axi_wready = !w_full && !bvalid;
    assign s_axi_arready = !rvalid;
    assign s_axi_bresp = bresp;
    assign s_axi_bvalid = bvalid;
    assign s_axi_rdata = rdata;
    assign s_axi_rresp = rresp;
    assign s_axi_rvalid = rvalid;

    // Pc high has no address of its own; reads show only the full pc word
    wire [31:0] rd_mux = (s_axi_araddr == REG_CMD) ? {23'h00_0000, pending, 8'h00} :
                         (s_axi_araddr == REG_WORK) ? {24'h00_0000, work} :
                         (s_axi_araddr == REG_STAT) ? {24'h00_0000, arith_status_reg} :
                         (s_axi_araddr == REG_PC) ? {16'h0000, pc} :
                         (s_axi_araddr == REG_LATCH) ? {24'h00_0000, pc_high_holding_latch} :
                         (s_axi_araddr == REG_FILE) ? {24'h00_0000, gpr} : 32'h0000_0000;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            div <= 2'h0;
        end else begin
            div <= div + 2'h1;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pending <= 1'b0;
            op_q <= OP_MOVF;
            dest_q <= 1'b0;
            bsel_q <= 3'h0;
            tgt_q <= TGT_STATUS;
        end else if (wr_cmd) begin
            pending <= 1'b1;
            op_q <= spae_op_t'(w_data_q[CMD_OP_LSB +: 4]);
            dest_q <= w_data_q[CMD_DEST_BIT];
            bsel_q <= w_data_q[CMD_BSEL_LSB +: 3];
            tgt_q <= spae_tgt_t'(w_data_q[CMD_TGT_LSB +: 2]);
        end else if (exec) begin
            pending <= 1'b0;
        end
    end

    // The instruction wins over a bus write landing in the same cycle
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            arith_status_reg <= STAT_RST;
            pc <= PC_RST;
            pc_high_holding_latch <= BYTE_ZERO;
            gpr <= BYTE_ZERO;
            work <= BYTE_ZERO;
        end else begin
            arith_status_reg <= next_status;
            pc <= next_pc;
            if (wr_f && tgt_q == TGT_LATCH) begin
                pc_high_holding_latch <= alu_bus.y;
            end else if (pc_low_read_only) begin
                pc_high_holding_latch <= pc_high_byte;
            end else if (wr_latch) begin
                pc_high_holding_latch <= w_data_q[7:0];
            end
            if (wr_f && tgt_q == TGT_FILE) begin
                gpr <= alu_bus.y;
            end else if (wr_gpr) begin
                gpr <= w_data_q[7:0];
            end
            if (wr_w) begin
                work <= alu_bus.y;
            end else if (wr_work) begin
                work <= w_data_q[7:0];
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_full <= 1'b0;
            w_full <= 1'b0;
            aw_addr_q <= '0;
            w_data_q <= 32'h0000_0000;
            w_strb_q <= 4'h0;
            bvalid <= 1'b0;
            bresp <= RESP_OKAY;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_full <= 1'b1;
                aw_addr_q <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_full <= 1'b1;
                w_data_q <= s_axi_wdata;
                w_strb_q <= s_axi_wstrb;
            end
            if (bus_commit) begin
                aw_full <= 1'b0;
                w_full <= 1'b0;
                bvalid <= 1'b1;
                bresp <= wr_refused ? RESP_SLVERR : RESP_OKAY;
            end else if (bvalid && s_axi_bready) begin
                bvalid <= 1'b0;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid <= 1'b0;
            rdata <= 32'h0000_0000;
            rresp <= RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            rvalid <= 1'b1;
            rdata <= rd_mux;
            rresp <= addr_known(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
        end else if (rvalid && s_axi_rready) begin
            rvalid <= 1'b0;
        end
    end

    property p_status_flags_override;
        @(posedge aclk) disable iff (!aresetn)
        (wr_f && tgt_q == TGT_STATUS) |=>
            ((arith_status_reg & {4'h0, $past(fmask)}) == {4'h0, $past(alu_bus.flags) & $past(fmask)});
    endproperty
    a_status_flags_override: assert property (p_status_flags_override)
        else $error("status write kept a written flag bit");

    property p_pc_low_read_latch;
        @(posedge aclk) disable iff (!aresetn)
        pc_low_read_only |=> (pc_high_holding_latch == $past(pc_high_byte)) && (pc == $past(pc) + 16'h0001);
    endproperty
    a_pc_low_read_latch: assert property (p_pc_low_read_latch)
        else $error("pc low read did not copy pc high into latch");

    property p_pc_low_write;
        @(posedge aclk) disable iff (!aresetn)
        (wr_f && tgt_q == TGT_PC_LOW) |=> (pc == {$past(pc_high_holding_latch), $past(alu_bus.y)});
    endproperty
    a_pc_low_write: assert property (p_pc_low_write)
        else $error("pc low write did not load pc from latch and result");

    property p_pc_low_rmw_operand;
        @(posedge aclk) disable iff (!aresetn)
        (exec && tgt_q == TGT_PC_LOW && op_q == OP_INCF && dest_q) |=> (pc[7:0] == $past(pc_low_byte) + 8'h01);
    endproperty
    a_pc_low_rmw_operand: assert property (p_pc_low_rmw_operand)
        else $error("pc low modify used a wrong operand");

    property p_pc_only_on_exec;
        @(posedge aclk) disable iff (!aresetn)
        !exec |=> $stable(pc);
    endproperty
    a_pc_only_on_exec: assert property (p_pc_only_on_exec)
        else $error("pc changed outside an instruction");

    property p_bit_op_whole;
        @(posedge aclk) disable iff (!aresetn)
        (exec && tgt_q == TGT_FILE && (op_q == OP_BSF || op_q == OP_BCF || op_q == OP_BTG)) |=>
            (((gpr ^ $past(gpr)) & ~(BIT0_MASK << $past(bsel_q))) == BYTE_ZERO);
    endproperty
    a_bit_op_whole: assert property (p_bit_op_whole)
        else $error("bit instruction disturbed other bits");

    property p_cycle_rate;
        @(posedge aclk) disable iff (!aresetn)
        cyc_en |=> !cyc_en [*3] ##1 cyc_en;
    endproperty
    a_cycle_rate: assert property (p_cycle_rate)
        else $error("instruction cycle not four clocks");

    property p_status_same_cycle;
        @(posedge aclk) disable iff (!aresetn)
        (exec && tgt_q == TGT_STATUS && op_q == OP_CLEAR) |=> arith_status_reg[FLG_Z] ##1 $stable(arith_status_reg);
    endproperty
    a_status_same_cycle: assert property (p_status_same_cycle)
        else $error("cleared status did not show zero flag at once");
endmodule

// ### sfr_pc_access_effects_test.sv
module sfr_pc_access_effects_test import spae_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;

    logic aclk;
    logic aresetn;
    logic [AXI_AW-1:0] s_axi_awaddr;
    logic s_axi_awvalid;
    logic s_axi_awready;
    logic [31:0] s_axi_wdata;
    logic s_axi_wvalid;
    logic s_axi_wready;
    logic [1:0] s_axi_bresp;
    logic s_axi_bvalid;
    logic s_axi_bready;
    logic [AXI_AW-1:0] s_axi_araddr;
    logic s_axi_arvalid;
    logic s_axi_arready;
    logic [31:0] s_axi_rdata;
    logic [1:0] s_axi_rresp;
    logic s_axi_rvalid;
    logic s_axi_rready;
    int cyc;
    int miscompares;
    int cmp_count;

    spae_core spae_core_i (
        .aclk(aclk),
        .aresetn(aresetn),
        .s_axi_awaddr(s_axi_awaddr),
        .s_axi_awprot(3'h0),
        .s_axi_awvalid(s_axi_awvalid),
        .s_axi_awready(s_axi_awready),
        .s_axi_wdata(s_axi_wdata),
        .s_axi_wstrb(4'hf),
        .s_axi_wvalid(s_axi_wvalid),
        .s_axi_wready(s_axi_wready),
        .s_axi_bresp(s_axi_bresp),
        .s_axi_bvalid(s_axi_bvalid),
        .s_axi_bready(s_axi_bready),
        .s_axi_araddr(s_axi_araddr),
        .s_axi_arprot(3'h0),
        .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(s_axi_arready),
        .s_axi_rdata(s_axi_rdata),
        .s_axi_rresp(s_axi_rresp),
        .s_axi_rvalid(s_axi_rvalid),
        .s_axi_rready(s_axi_rready)
    );

    always #5 aclk = ~aclk;

    // Edge index since reset release; instruction slots fall on multiples of four
    always @(posedge aclk) cyc <= aresetn ? cyc + 1 : 0;

    task automatic give_verdict();
        $display("comparisons %0d, mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
        cmp_count++;
        if (got !== exp) begin
            miscompares++;
            $display("unexpected at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    // Returns the edge index at which the command was committed
    task automatic axi_write(input logic [4:0] a, input logic [31:0] d, output logic [1:0] r, output int e);
        int n;
        n = 0;
        e = 0;
        r = 2'bxx;
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        do begin
            @(posedge aclk);
            n++;
            if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid) begin
                r = s_axi_bresp;
                e = cyc;
            end
        end while (e == 0 && n < 50);
    endtask

    // Returns the edge index at which the address was taken
    task automatic axi_read(input logic [4:0] a, output logic [31:0] d, output logic [1:0] r, output int t);
        int n;
        n = 0;
        t = 0;
        d = 'x;
        r = 2'bxx;
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        do begin
            @(posedge aclk);
            n++;
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_arvalid <= 1'b0;
                t = cyc + 1;
            end
            if (s_axi_rvalid) begin
                d = s_axi_rdata;
                r = s_axi_rresp;
                n = 99;
            end
        end while (n < 50);
    endtask

    task automatic wr(input logic [4:0] a, input logic [31:0] d, input logic [1:0] er);
        logic [1:0] r;
        int e;
        axi_write(a, d, r, e);
        check(32'(r), 32'(er), "write response");
    endtask

    task automatic rd(input logic [4:0] a, input logic [31:0] exp, input logic [1:0] er);
        logic [31:0] d;
        logic [1:0] r;
        int t;
        axi_read(a, d, r, t);
        check(d, exp, "read data");
        check(32'(r), 32'(er), "read response");
    endtask

    // Busy must drop exactly after the first slot edge past the commit edge
    task automatic cmd(input spae_op_t op, input logic dest, input logic [2:0] bs, input spae_tgt_t tg);
        logic [31:0] d;
        logic [1:0] r;
        int e;
        int x;
        int t;
        int k;
        axi_write(REG_CMD, 32'({tg, bs, dest, op}), r, e);
        check(32'(r), 32'(RESP_OKAY), "command response");
        x = e + 1;
        while (x % CYC_DIV != 0) x++;
        k = 0;
        do begin
            axi_read(REG_CMD, d, r, t);
            check(32'(d[CMD_BUSY_BIT]), 32'(x >= t), "busy");
            k++;
        end while (d[CMD_BUSY_BIT] !== 1'b0 && k < 8);
    endtask

    task automatic t_reset();
        rd(REG_STAT, 32'h0000_0000, RESP_OKAY);
        rd(REG_PC, 32'h0000_0000, RESP_OKAY);
        rd(REG_LATCH, 32'h0000_0000, RESP_OKAY);
        rd(5'h18, 32'h0000_0000, RESP_SLVERR);
    endtask

    task automatic t_status();
        cmd(OP_CLEAR, 1'b1, 3'h0, TGT_STATUS);
        rd(REG_STAT, 32'h0000_0004, RESP_OKAY);
        wr(REG_STAT, 32'h0000_00ff, RESP_SLVERR);
        rd(REG_STAT, 32'h0000_0004, RESP_OKAY);
        wr(REG_WORK, 32'h0000_00fc, RESP_OKAY);
        // 0x04 + 0xfc wraps to zero with carry and digit carry, no overflow
        cmd(OP_ADDWF, 1'b1, 3'h0, TGT_STATUS);
        rd(REG_STAT, 32'h0000_0007, RESP_OKAY);
        cmd(OP_MOVF, 1'b0, 3'h0, TGT_STATUS);
        rd(REG_WORK, 32'h0000_0007, RESP_OKAY);
        rd(REG_PC, 32'h0000_0003, RESP_OKAY);
    endtask

    task automatic t_pc();
        wr(REG_LATCH, 32'h0000_0012, RESP_OKAY);
        wr(REG_WORK, 32'h0000_0034, RESP_OKAY);
        cmd(OP_MOVWF, 1'b1, 3'h0, TGT_PC_LOW);
        rd(REG_PC, 32'h0000_1234, RESP_OKAY);
        wr(REG_LATCH, 32'h0000_0000, RESP_OKAY);
        cmd(OP_MOVF, 1'b0, 3'h0, TGT_PC_LOW);
        rd(REG_WORK, 32'h0000_0034, RESP_OKAY);
        rd(REG_LATCH, 32'h0000_0012, RESP_OKAY);
        rd(REG_PC, 32'h0000_1235, RESP_OKAY);
        wr(REG_LATCH, 32'h0000_0056, RESP_OKAY);
        cmd(OP_INCF, 1'b1, 3'h0, TGT_PC_LOW);
        rd(REG_PC, 32'h0000_5636, RESP_OKAY);
        wr(REG_PC, 32'h0000_ffff, RESP_SLVERR);
        rd(REG_PC, 32'h0000_5636, RESP_OKAY);
        rd(REG_LATCH, 32'h0000_0056, RESP_OKAY);
    endtask

    task automatic t_bits();
        wr(REG_FILE, 32'h0000_00a5, RESP_OKAY);
        cmd(OP_BSF, 1'b1, 3'h1, TGT_FILE);
        rd(REG_FILE, 32'h0000_00a7, RESP_OKAY);
        cmd(OP_BCF, 1'b1, 3'h0, TGT_FILE);
        rd(REG_FILE, 32'h0000_00a6, RESP_OKAY);
        cmd(OP_BTG, 1'b1, 3'h7, TGT_FILE);
        rd(REG_FILE, 32'h0000_0026, RESP_OKAY);
    endtask

    // Subtract and AND, with the holding latch as an instruction operand
    task automatic t_arith();
        wr(REG_WORK, 32'h0000_0001, RESP_OKAY);
        wr(REG_FILE, 32'h0000_0080, RESP_OKAY);
        // 0x80 - 0x01 gives 0x7f: no borrow, nibble borrow, signed overflow
        cmd(OP_SUBWF, 1'b1, 3'h0, TGT_FILE);
        rd(REG_FILE, 32'h0000_007f, RESP_OKAY);
        rd(REG_STAT, 32'h0000_0009, RESP_OKAY);
        cmd(OP_ANDWF, 1'b0, 3'h0, TGT_LATCH);
        rd(REG_WORK, 32'h0000_0000, RESP_OKAY);
        rd(REG_STAT, 32'h0000_000d, RESP_OKAY);
        rd(REG_LATCH, 32'h0000_0056, RESP_OKAY);
        rd(REG_PC, 32'h0000_563b, RESP_OKAY);
    endtask

    initial begin
        aclk = 1'b0;
        aresetn = 1'b0;
        miscompares = 0;
        cmp_count = 0;
        s_axi_awaddr = 5'h00;
        s_axi_awvalid = 1'b0;
        s_axi_wdata = 32'h0000_0000;
        s_axi_wvalid = 1'b0;
        // Response readies stay up, so back-to-back calls never toggle them in one step
        s_axi_bready = 1'b1;
        s_axi_araddr = 5'h00;
        s_axi_arvalid = 1'b0;
        s_axi_rready = 1'b1;
        repeat (8) @(posedge aclk);
        aresetn <= 1'b1;
        t_reset();
        t_status();
        t_pc();
        t_bits();
        t_arith();
        give_verdict();
    end

    // The whole sequence needs well under two thousand cycles
    initial begin
        repeat (20000) @(posedge aclk);
        miscompares++;
        give_verdict();
    end
endmodule
